/* design/urpa_pkg.sv */
// package for the uart register page access block
package urpa_pkg;
	// register indices on the host bus (byte address = index * 4)
	localparam logic [2:0] URPA_IDX_0 = 3'h0;
	localparam logic [2:0] URPA_IDX_1 = 3'h1;
	localparam logic [2:0] URPA_IDX_2 = 3'h2;
	localparam logic [2:0] URPA_IDX_3 = 3'h3;
	localparam logic [2:0] URPA_IDX_4 = 3'h4;
	localparam logic [2:0] URPA_IDX_5 = 3'h5;
	localparam logic [2:0] URPA_IDX_6 = 3'h6;
	localparam logic [2:0] URPA_IDX_7 = 3'h7;
	// block status/count inputs placed above the uart map
	localparam logic [4:0] URPA_IDX_TXCNT_IN = 5'h08;
	localparam logic [4:0] URPA_IDX_RXCNT_IN = 5'h09;
	localparam logic [4:0] URPA_IDX_FLOW_IN  = 5'h0A;
	localparam logic [4:0] URPA_IDX_STAT_IN  = 5'h0B;
	localparam logic [4:0] URPA_IDX_LAST     = 5'h0B;

	localparam logic [7:0] URPA_LNC_DIV   = 8'h80;
	localparam logic [7:0] URPA_LNC_ENH   = 8'hBF;
	localparam logic [7:0] URPA_LNC_8N1   = 8'h03;
	localparam logic [7:0] URPA_PGS_ADV   = 8'hA5;
	localparam logic [7:0] URPA_PGS_NORM  = 8'hA4;
	localparam logic [7:0] URPA_ADF_256   = 8'h01;
	localparam logic [7:0] URPA_LNC_RST   = 8'h00;
	localparam logic [7:0] URPA_DIV_RST   = 8'h01;

	localparam int URPA_LNC_DLAB   = 7;
	localparam int URPA_MDC_PRESC  = 7;
	localparam int URPA_MDC_ALT    = 6;
	localparam int URPA_MDC_XRT    = 2;
	localparam int URPA_ENF_PRESW  = 4;
	localparam int URPA_FFC_EN     = 0;
	localparam int URPA_IEN_RX     = 0;
	localparam int URPA_IEN_TX     = 1;
	localparam int URPA_IST_TXE    = 7;
	localparam int URPA_IST_RXF    = 6;
	localparam int URPA_WLEN_HI    = 1;
	localparam int URPA_WLEN_LO    = 0;
	localparam int URPA_STOP_BIT   = 2;
	localparam int URPA_PAR_BIT    = 3;
	localparam int URPA_FCODE_HI   = 7;
	localparam int URPA_FCODE_LO   = 4;

	localparam logic [3:0] URPA_CODE_0 = 4'h0;
	localparam logic [3:0] URPA_CODE_1 = 4'h5;
	localparam logic [3:0] URPA_CODE_2 = 4'hA;
	localparam logic [3:0] URPA_CODE_3 = 4'hF;
	localparam logic [7:0] URPA_V8  = 8'h08;
	localparam logic [7:0] URPA_V0  = 8'h00;
	localparam logic [7:0] URPA_V16 = 8'h10;
	localparam logic [7:0] URPA_V32 = 8'h20;
	localparam logic [7:0] URPA_V56 = 8'h38;
	localparam logic [7:0] URPA_V60 = 8'h3C;

	// decoded line settings
	typedef struct packed {
		logic [1:0] word_len;
		logic       two_stop;
		logic       parity_en;
	} urpa_line_t;

	// levels handed to the datapath
	typedef struct packed {
		logic [7:0] flow_upper;
		logic [7:0] flow_lower;
		logic [7:0] rx_trig;
		logic [7:0] tx_trig;
	} urpa_levels_t;

	// which map the bus currently sees
	typedef enum logic [3:0] {
		URPA_MAP_BASE = 4'b0001,
		URPA_MAP_DIV  = 4'b0010,
		URPA_MAP_ENH  = 4'b0100,
		URPA_MAP_ALT  = 4'b1000
	} urpa_map_t;
endpackage

/* design/urpa_top.sv */
// register paging and access decode for one uart channel
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/10ps
// What this block does
// - line control 80h maps divisor low and high bytes at indices 0 and 1
// - line control BFh exposes both resume and pause character pairs
// - enhanced feature register reachable only while line control is BFh
// - 64-byte mode: fifo code bits 7:4 fix flow upper and lower thresholds
// - 64-byte mode: same code fixes receive and transmit trigger levels
// - at BFh, page A5h shows advanced registers, A4h returns normal page
// - fifo enable set, then advanced fifo write 01h selects 256-byte mode
// - 256-byte mode takes trigger levels from host-written registers
// - 256-byte mode takes flow thresholds from host-written registers
// - line bit7 clear and modem bit6 set shows flow status register
// - same condition shows fifo counts; clearing modem bit6 restores map
// - 256-byte mode: status read reports tx empty and rx full
// - modem bit6 set first, then write with bits 6 and 2 enables re-send
// - modem bit6 set first, then write with bits 6,2 clear disables it
// - enhanced feature bit4 permits writes to modem bit7
// - modem bit7 picks prescaler: clear divides by 1, set by 4
// - divisor is high byte over low byte, 16 bits
// - line control 03h gives eight bits, no parity, one stop
// - enable register 03h enables receive and transmit interrupts
module urpa_top
	import urpa_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]   pwdata,
	input  wire logic [3:0]    pstrb,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic [7:0]    rx_data_in,
	input  wire logic [7:0]    base_status_in,
	input  wire logic [7:0]    flow_status_in,
	input  wire logic [8:0]    tx_count_in,
	input  wire logic [8:0]    rx_count_in,
	input  wire logic          tx_empty_in,
	input  wire logic          rx_full_in,
	output logic      [7:0]    tx_data_out,
	output logic               tx_data_stb,
	output logic      [15:0]   baud_divisor,
	output logic               prescale_div4,
	output logic               fifo_256_mode,
	output logic               xoff_resend_en,
	output logic      [7:0]    flow_mode,
	output urpa_levels_t       levels,
	output urpa_line_t         line_cfg,
	output logic               rx_irq_en,
	output logic               tx_irq_en
);

	// the word index sits in paddr[6:2], so a narrower bus cannot be served
	if (ADDR_W < 7) begin : g_addr_check
		$error("urpa_top: ADDR_W must be at least 7");
	end

	logic [7:0] line_control_reg_r;
	logic [7:0] modem_control_reg_r;
	logic [7:0] fifo_control_reg_r;
	logic [7:0] interrupt_enable_reg_r;
	logic [7:0] enhanced_feature_reg_r;
	logic [7:0] page_select_reg_r;
	logic [7:0] advanced_fifo_reg_r;
	logic [7:0] divisor_low_byte_r;
	logic [7:0] divisor_high_byte_r;
	logic [7:0] resume_char_first_r;
	logic [7:0] resume_char_second_r;
	logic [7:0] pause_char_first_r;
	logic [7:0] pause_char_second_r;
	logic [7:0] flow_upper_threshold_r;
	logic [7:0] flow_lower_threshold_r;
	logic [7:0] rx_trigger_level_r;
	logic [7:0] tx_trigger_level_r;
	logic [7:0] scratch_r;
	logic       alt_armed_r;

	urpa_map_t  map;
	logic       adv_page;
	logic       access;
	logic       wr;
	logic       rd;
	logic [4:0] idx;
	logic       idx_hi_zero;
	logic [7:0] wd;
	logic [7:0] rd_nxt;
	logic       err_nxt;
	urpa_levels_t levels_nxt;
	logic [3:0] fifo_code;

	assign access = psel && penable && !pready;
	assign wr = access && pwrite && pstrb[0];
	assign rd = access && !pwrite;
	assign idx = paddr[6:2];
	assign idx_hi_zero = (ADDR_W > 7) ? (paddr[ADDR_W-1:7] == '0) : 1'b1;
	assign wd = pwdata[7:0];
	assign adv_page = (page_select_reg_r == URPA_PGS_ADV);
	assign fifo_code = fifo_control_reg_r[URPA_FCODE_HI:URPA_FCODE_LO];

	// map selection; divisor decode keys on the exact code, not bit 7 alone
	always_comb begin
		if (line_control_reg_r == URPA_LNC_ENH)
			map = URPA_MAP_ENH;
		else if (line_control_reg_r == URPA_LNC_DIV)
			map = URPA_MAP_DIV;
		else if (!line_control_reg_r[URPA_LNC_DLAB]
				&& modem_control_reg_r[URPA_MDC_ALT])
			map = URPA_MAP_ALT;
		else
			map = URPA_MAP_BASE;
	end

	// read mux
	// the fixed views at 08h-0Bh come first so no page can hide them
	always_comb begin
		rd_nxt  = URPA_V0;
		err_nxt = 1'b0;
		if (!idx_hi_zero || idx > URPA_IDX_LAST || paddr[1:0] != 2'b00) begin
			err_nxt = 1'b1;
		end else if (idx == URPA_IDX_TXCNT_IN) begin
			rd_nxt = tx_count_in[7:0];
		end else if (idx == URPA_IDX_RXCNT_IN) begin
			rd_nxt = rx_count_in[7:0];
		end else if (idx == URPA_IDX_FLOW_IN) begin
			rd_nxt = flow_status_in;
		end else if (idx == URPA_IDX_STAT_IN) begin
			rd_nxt = base_status_in;
		end else if (map == URPA_MAP_DIV && idx == {2'b00, URPA_IDX_0}) begin
			rd_nxt = divisor_low_byte_r;
		end else if (map == URPA_MAP_DIV && idx == {2'b00, URPA_IDX_1}) begin
			rd_nxt = divisor_high_byte_r;
		end else if (map == URPA_MAP_ENH && adv_page
				&& idx == {2'b00, URPA_IDX_0}) begin
			rd_nxt = advanced_fifo_reg_r;
		end else if (map == URPA_MAP_ENH && adv_page
				&& idx == {2'b00, URPA_IDX_1}) begin
			rd_nxt = flow_upper_threshold_r;
		end else if (map == URPA_MAP_ENH && adv_page
				&& idx == {2'b00, URPA_IDX_2}) begin
			rd_nxt = flow_lower_threshold_r;
		end else if (map == URPA_MAP_ENH && adv_page
				&& idx == {2'b00, URPA_IDX_4}) begin
			rd_nxt = rx_trigger_level_r;
		end else if (map == URPA_MAP_ENH && adv_page
				&& idx == {2'b00, URPA_IDX_5}) begin
			rd_nxt = tx_trigger_level_r;
		end else if (map == URPA_MAP_ENH && idx == {2'b00, URPA_IDX_2}) begin
			rd_nxt = enhanced_feature_reg_r;
		end else if (map == URPA_MAP_ENH && idx == {2'b00, URPA_IDX_4}) begin
			rd_nxt = resume_char_first_r;
		end else if (map == URPA_MAP_ENH && idx == {2'b00, URPA_IDX_5}) begin
			rd_nxt = resume_char_second_r;
		end else if (map == URPA_MAP_ENH && idx == {2'b00, URPA_IDX_6}) begin
			rd_nxt = pause_char_first_r;
		end else if (map == URPA_MAP_ENH && idx == {2'b00, URPA_IDX_7}) begin
			rd_nxt = pause_char_second_r;
		end else if (map == URPA_MAP_ALT && idx == {2'b00, URPA_IDX_0}) begin
			rd_nxt = tx_count_in[7:0];
		end else if (map == URPA_MAP_ALT && idx == {2'b00, URPA_IDX_1}) begin
			rd_nxt = rx_count_in[7:0];
		end else if (map == URPA_MAP_ALT && idx == {2'b00, URPA_IDX_5}) begin
			rd_nxt = flow_status_in;
		end else if (idx == {2'b00, URPA_IDX_0}) begin
			rd_nxt = rx_data_in;
		end else if (idx == {2'b00, URPA_IDX_1}) begin
			rd_nxt = interrupt_enable_reg_r;
		end else if (idx == {2'b00, URPA_IDX_2}) begin
			rd_nxt = base_status_in;
			if (fifo_256_mode) begin
				rd_nxt[URPA_IST_TXE] = tx_empty_in;
				rd_nxt[URPA_IST_RXF] = rx_full_in;
			end
		end else if (idx == {2'b00, URPA_IDX_3}) begin
			rd_nxt = line_control_reg_r;
		end else if (idx == {2'b00, URPA_IDX_4}) begin
			rd_nxt = modem_control_reg_r;
		end else if (idx == {2'b00, URPA_IDX_5}) begin
			rd_nxt = base_status_in;
		end else if (idx == {2'b00, URPA_IDX_7}) begin
			rd_nxt = scratch_r;
		end
	end

	// apb answer: one wait state, pready raised for a single cycle
	// a refused access still answers, with the error flag beside ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= access && err_nxt;
			if (rd)
				prdata <= {24'h00_0000, rd_nxt};
		end
	end

	// line control is writable in every map so software can always escape
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			line_control_reg_r <= URPA_LNC_RST;
		else if (wr && !err_nxt && idx == {2'b00, URPA_IDX_3})
			line_control_reg_r <= wd;
	end

	// modem control, with the armed step for the re-send sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modem_control_reg_r <= URPA_V0;
			alt_armed_r         <= 1'b0;
			xoff_resend_en      <= 1'b0;
		end else if (wr && !err_nxt && map != URPA_MAP_ENH
				&& idx == {2'b00, URPA_IDX_4}) begin
			modem_control_reg_r[URPA_MDC_PRESC-1:0] <= wd[URPA_MDC_PRESC-1:0];
			// bit 7 moves only while the enhanced feature bit unlocks it
			if (enhanced_feature_reg_r[URPA_ENF_PRESW])
				modem_control_reg_r[URPA_MDC_PRESC] <= wd[URPA_MDC_PRESC];
			// every write re-arms or disarms, so arming must come just before
			alt_armed_r <= wd[URPA_MDC_ALT];
			if (alt_armed_r && wd[URPA_MDC_ALT] && wd[URPA_MDC_XRT])
				xoff_resend_en <= 1'b1;
			else if (alt_armed_r && !wd[URPA_MDC_ALT] && !wd[URPA_MDC_XRT])
				xoff_resend_en <= 1'b0;
		end
	end

	// base page registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_enable_reg_r <= URPA_V0;
			fifo_control_reg_r     <= URPA_V0;
			scratch_r              <= URPA_V0;
			tx_data_out            <= URPA_V0;
			tx_data_stb            <= 1'b0;
		end else begin
			// one-cycle strobe per transmit byte; nothing is buffered here
			tx_data_stb <= 1'b0;
			if (wr && !err_nxt && map != URPA_MAP_DIV
					&& map != URPA_MAP_ENH) begin
				if (idx == {2'b00, URPA_IDX_0}) begin
					tx_data_out <= wd;
					tx_data_stb <= 1'b1;
				end else if (idx == {2'b00, URPA_IDX_1}) begin
					interrupt_enable_reg_r <= wd;
				end else if (idx == {2'b00, URPA_IDX_2}) begin
					fifo_control_reg_r <= wd;
				end else if (idx == {2'b00, URPA_IDX_7}) begin
					scratch_r <= wd;
				end
			end
		end
	end

	// divisor latches
	// reset to 0001h so the baud generator sees no zero divisor until the host writes one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divisor_low_byte_r  <= URPA_DIV_RST;
			divisor_high_byte_r <= URPA_V0;
		end else if (wr && !err_nxt && map == URPA_MAP_DIV) begin
			if (idx == {2'b00, URPA_IDX_0})
				divisor_low_byte_r <= wd;
			else if (idx == {2'b00, URPA_IDX_1})
				divisor_high_byte_r <= wd;
		end
	end

	// enhanced page and advanced page registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enhanced_feature_reg_r <= URPA_V0;
			page_select_reg_r      <= URPA_PGS_NORM;
			advanced_fifo_reg_r    <= URPA_V0;
			resume_char_first_r    <= URPA_V0;
			resume_char_second_r   <= URPA_V0;
			pause_char_first_r     <= URPA_V0;
			pause_char_second_r    <= URPA_V0;
			flow_upper_threshold_r <= URPA_V0;
			flow_lower_threshold_r <= URPA_V0;
			rx_trigger_level_r     <= URPA_V0;
			tx_trigger_level_r     <= URPA_V0;
		end else if (wr && !err_nxt && map == URPA_MAP_ENH) begin
			if (idx == {2'b00, URPA_IDX_1}) begin
				if (adv_page)
					flow_upper_threshold_r <= wd;
			end else if (idx == {2'b00, URPA_IDX_0}) begin
				if (adv_page)
					advanced_fifo_reg_r <= wd;
			end else if (idx == {2'b00, URPA_IDX_2}) begin
				if (adv_page)
					flow_lower_threshold_r <= wd;
				else
					enhanced_feature_reg_r <= wd;
			end else if (idx == {2'b00, URPA_IDX_3}) begin
				// line control at this index has its own process
			end else if (idx == {2'b00, URPA_IDX_4}) begin
				if (adv_page)
					rx_trigger_level_r <= wd;
				else
					resume_char_first_r <= wd;
			end else if (idx == {2'b00, URPA_IDX_5}) begin
				if (adv_page)
					tx_trigger_level_r <= wd;
				else
					resume_char_second_r <= wd;
			end else if (idx == {2'b00, URPA_IDX_6}) begin
				if (adv_page)
					page_select_reg_r <= wd;
				// A5h here turns the page, so it cannot be a pause character
				else if (wd == URPA_PGS_ADV)
					page_select_reg_r <= wd;
				else
					pause_char_first_r <= wd;
			end else if (idx == {2'b00, URPA_IDX_7}) begin
				pause_char_second_r <= wd;
			end
		end
	end

	// fixed 64-byte levels from the fifo code, host values in 256 mode
	// codes other than 0, 5, A and F fall back to the code-0 levels
	always_comb begin
		levels_nxt = '{URPA_V8, URPA_V0, URPA_V8, URPA_V8};
		if (fifo_256_mode) begin
			levels_nxt = '{flow_upper_threshold_r, flow_lower_threshold_r,
				rx_trigger_level_r, tx_trigger_level_r};
		end else if (fifo_code == URPA_CODE_1) begin
			levels_nxt = '{URPA_V16, URPA_V8, URPA_V16, URPA_V16};
		end else if (fifo_code == URPA_CODE_2) begin
			levels_nxt = '{URPA_V56, URPA_V16, URPA_V56, URPA_V32};
		end else if (fifo_code == URPA_CODE_3) begin
			levels_nxt = '{URPA_V60, URPA_V56, URPA_V60, URPA_V56};
		end
	end

	// outputs registered from the state above
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_divisor  <= {URPA_V0, URPA_DIV_RST};
			prescale_div4 <= 1'b0;
			fifo_256_mode <= 1'b0;
			flow_mode     <= URPA_V0;
			levels        <= '0;
			line_cfg      <= '0;
			rx_irq_en     <= 1'b0;
			tx_irq_en     <= 1'b0;
		end else begin
			baud_divisor  <= {divisor_high_byte_r, divisor_low_byte_r};
			prescale_div4 <= modem_control_reg_r[URPA_MDC_PRESC];
			fifo_256_mode <= fifo_control_reg_r[URPA_FFC_EN]
				&& advanced_fifo_reg_r == URPA_ADF_256;
			flow_mode     <= enhanced_feature_reg_r;
			levels        <= levels_nxt;
			line_cfg      <= '{
				line_control_reg_r[URPA_WLEN_HI:URPA_WLEN_LO],
				line_control_reg_r[URPA_STOP_BIT],
				line_control_reg_r[URPA_PAR_BIT]};
			rx_irq_en     <= interrupt_enable_reg_r[URPA_IEN_RX];
			tx_irq_en     <= interrupt_enable_reg_r[URPA_IEN_TX];
		end
	end

endmodule // urpa_top

/* sim/testbench.sv */
// self-checking bench for the uart page access block
`timescale 1ns/10ps
module testbench;
	import urpa_pkg::*;
	typedef struct packed {
		logic [7:0] d;
		logic       c;
		logic       e;
	} urpa_note_t;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]   paddr, rx_data_in, base_status_in, flow_status_in;
	logic [31:0]  pwdata, prdata;
	logic [3:0]   pstrb;
	logic [8:0]   tx_count_in, rx_count_in;
	logic         tx_empty_in, rx_full_in, tx_data_stb, prescale_div4;
	logic         fifo_256_mode, xoff_resend_en, rx_irq_en, tx_irq_en;
	logic [7:0]   tx_data_out, flow_mode, lo, hi;
	logic [15:0]  baud_divisor;
	urpa_levels_t levels;
	urpa_line_t   line_cfg;
	urpa_note_t   q[$];
	urpa_note_t   nt;
	logic [7:0]   v[8], w[8];
	logic [3:0]   cd[4] = '{URPA_CODE_0, URPA_CODE_1, URPA_CODE_2, URPA_CODE_3};
	logic [31:0]  lv[4] = '{32'h08000808, 32'h10081010, 32'h38103820,
		32'h3C383C38};
	int           errors, compares, cyc, stb_n;

	urpa_top #(.ADDR_W(8)) urpa_top_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_data_in(rx_data_in),
		.base_status_in(base_status_in), .flow_status_in(flow_status_in),
		.tx_count_in(tx_count_in), .rx_count_in(rx_count_in),
		.tx_empty_in(tx_empty_in), .rx_full_in(rx_full_in),
		.tx_data_out(tx_data_out), .tx_data_stb(tx_data_stb),
		.baud_divisor(baud_divisor), .prescale_div4(prescale_div4),
		.fifo_256_mode(fifo_256_mode), .xoff_resend_en(xoff_resend_en),
		.flow_mode(flow_mode), .levels(levels), .line_cfg(line_cfg),
		.rx_irq_en(rx_irq_en), .tx_irq_en(tx_irq_en));

	task automatic final_report;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x,
		input string nm);
		compares++;
		if (s !== x) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask
	// the request is held until the edge that samples pready high
	task automatic xfer(input logic [7:0] a, input logic wd,
		input logic [7:0] d, input logic [7:0] x, input logic c, input logic e);
		int n;
		q.push_back('{x, c, e});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wd;
		pwdata <= {24'h0, d};
		pstrb <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk(32'(pready), 32'h1, "pready wait");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] i, input logic [7:0] d);
		xfer({1'b0, i, 2'b00}, 1'b1, d, 8'h00, 1'b0, 1'b0);
	endtask
	task automatic rd(input logic [4:0] i, input logic [7:0] x);
		xfer({1'b0, i, 2'b00}, 1'b0, 8'h00, x, 1'b1, 1'b0);
	endtask
	// outputs lag the register by one cycle
	task automatic settle;
		repeat (2) @(posedge pclk);
		#1;
	endtask

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			chk(32'h1, 32'h0, "cycle limit");
			final_report;
		end
	end
	always @(posedge pclk) begin
		if (tx_data_stb === 1'b1)
			stb_n++;
		if (pready === 1'b1) begin
			if (q.size() == 0)
				chk(32'h1, 32'h0, "unexpected answer");
			else begin
				nt = q.pop_front();
				if (nt.c)
					chk(prdata, {24'h0, nt.d}, "prdata");
				chk(32'(pslverr), 32'(nt.e), "pslverr");
			end
		end
	end

	initial begin
		{presetn, psel, penable, pwrite, tx_empty_in, rx_full_in} = '0;
		{paddr, rx_data_in, base_status_in, flow_status_in} = '0;
		{pwdata, pstrb, tx_count_in, rx_count_in} = '0;
		void'($urandom(7126));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		base_status_in <= 8'($urandom);
		flow_status_in <= 8'($urandom);
		tx_count_in <= 9'($urandom);
		rx_count_in <= 9'($urandom);
		tx_empty_in <= 1'($urandom);
		rx_full_in <= 1'($urandom);
		rx_data_in <= 8'($urandom);
		settle;
		chk(32'(baud_divisor), 32'h0001, "divisor reset");
		rd(5'h03, URPA_LNC_RST);
		lo = 8'($urandom);
		hi = 8'($urandom);
		wr(5'h03, URPA_LNC_DIV);
		wr(5'h00, lo);
		wr(5'h01, hi);
		rd(5'h00, lo);
		rd(5'h01, hi);
		wr(5'h03, URPA_LNC_8N1);
		wr(5'h01, 8'h03);
		rd(5'h01, 8'h03);
		rd(5'h00, rx_data_in);
		wr(5'h00, hi);
		settle;
		chk(32'(baud_divisor), {16'h0, hi, lo}, "divisor");
		chk(32'(tx_data_out), 32'(hi), "tx data");
		chk(32'(stb_n), 32'h1, "tx strobes");
		chk(32'(line_cfg), 32'hC, "line cfg");
		chk(32'({rx_irq_en, tx_irq_en}), 32'h3, "irq enables");
		$display("test divisor and line done");
		for (int i = 2; i < 8; i++)
			v[i] = 8'($urandom);
		v[2][4] = 1'b0;
		if (v[6] == URPA_PGS_ADV)
			v[6] = 8'h5A;
		wr(5'h03, URPA_LNC_ENH);
		for (int i = 2; i < 8; i++)
			if (i != 3)
				wr(5'(i), v[i]);
		for (int i = 2; i < 8; i++)
			if (i != 3)
				rd(5'(i), v[i]);
		settle;
		chk(32'(flow_mode), 32'(v[2]), "flow mode");
		wr(5'h03, URPA_LNC_8N1);
		for (int k = 0; k < 4; k++) begin
			wr(5'h02, {cd[k], 4'h1});
			settle;
			chk(levels, lv[k], "levels 64");
		end
		$display("test flow chars and codes done");
		for (int i = 1; i < 6; i++)
			w[i] = 8'($urandom);
		w[0] = URPA_ADF_256;
		wr(5'h02, 8'h01);
		wr(5'h03, URPA_LNC_ENH);
		wr(5'h06, URPA_PGS_ADV);
		for (int i = 0; i < 6; i++)
			if (i != 3)
				wr(5'(i), w[i]);
		for (int i = 0; i < 6; i++)
			if (i != 3)
				rd(5'(i), w[i]);
		wr(5'h06, URPA_PGS_NORM);
		rd(5'h04, v[4]);
		wr(5'h03, URPA_LNC_8N1);
		settle;
		chk(32'(fifo_256_mode), 32'h1, "256 mode");
		chk(levels, {w[1], w[2], w[4], w[5]}, "levels 256");
		rd(5'h02, {tx_empty_in, rx_full_in, base_status_in[5:0]});
		$display("test 256 mode done");
		wr(5'h04, 8'h40);
		rd(5'h00, tx_count_in[7:0]);
		rd(5'h01, rx_count_in[7:0]);
		rd(5'h05, flow_status_in);
		wr(5'h04, 8'h44);
		settle;
		chk(32'(xoff_resend_en), 32'h1, "resend on");
		wr(5'h04, 8'h04);
		rd(5'h01, 8'h03);
		wr(5'h04, 8'h40);
		wr(5'h04, 8'h00);
		settle;
		chk(32'(xoff_resend_en), 32'h0, "resend off");
		wr(5'h04, 8'h80);
		settle;
		chk(32'(prescale_div4), 32'h0, "prescale locked");
		wr(5'h03, URPA_LNC_ENH);
		wr(5'h02, v[2] | 8'h10);
		wr(5'h03, URPA_LNC_RST);
		wr(5'h04, 8'h80);
		settle;
		chk(32'(prescale_div4), 32'h1, "prescale div4");
		wr(5'h04, 8'h00);
		settle;
		chk(32'(prescale_div4), 32'h0, "prescale div1");
		$display("test alternate map and modem done");
		xfer(8'h0D, 1'b1, 8'h55, 8'h00, 1'b0, 1'b1);
		xfer(8'h30, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1);
		xfer(8'h8C, 1'b1, 8'h11, 8'h00, 1'b0, 1'b1);
		rd(5'h03, URPA_LNC_RST);
		rd(5'h08, tx_count_in[7:0]);
		$display("test refused accesses done");
		repeat (4) @(posedge pclk);
		final_report;
	end
endmodule // testbench

/* sim/urpa_top_props.sv */
// concurrent checks on the page access block ports
`timescale 1ns/10ps
module urpa_top_props
	import urpa_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input logic              pclk,
	input logic              presetn,
	input logic              psel,
	input logic              penable,
	input logic              pwrite,
	input logic [ADDR_W-1:0] paddr,
	input logic [31:0]       prdata,
	input logic              pready,
	input logic              pslverr,
	input logic              tx_data_stb,
	input logic [15:0]       baud_divisor,
	input logic              prescale_div4,
	input logic              fifo_256_mode,
	input logic              xoff_resend_en,
	input logic [7:0]        flow_mode,
	input urpa_levels_t      levels,
	input urpa_line_t        line_cfg,
	input logic              rx_irq_en,
	input logic              tx_irq_en
);
	logic wr_done;
	logic bad_addr;
	assign wr_done = pready && pwrite;
	// high address bits alias nothing, so they must be refused
	assign bad_addr = (paddr[1:0] != 2'b00) || (paddr[6:2] > 5'h0B)
		|| ((paddr >> 7) != '0);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_wait_state: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("answer not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside an access");
	a_err_decode: assert property (pready |-> pslverr == bad_addr)
		else $error("error response does not match address");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_cfg_cause: assert property (
		$changed({baud_divisor, line_cfg, prescale_div4, flow_mode,
		rx_irq_en, tx_irq_en, fifo_256_mode})
		|-> $past(wr_done)) else $error("setting changed without a write");
	a_resend_cause: assert property (
		$changed(xoff_resend_en) |-> wr_done)
		else $error("re-send enable changed outside a write");
	a_lvl64_table: assert property (
		$past(presetn) && $past(presetn, 2) && !fifo_256_mode
		&& !$past(fifo_256_mode) |-> levels inside {32'h08000808,
		32'h10081010, 32'h38103820, 32'h3C383C38})
		else $error("64-byte levels off the fixed table");
	a_stb_pulse: assert property (tx_data_stb |=> !tx_data_stb)
		else $error("transmit strobe longer than one cycle");
	c_read: cover property (pready && !pwrite);
	c_error: cover property (pslverr);
	c_mode256: cover property ($rose(fifo_256_mode));
endmodule // urpa_top_props

bind urpa_top urpa_top_props #(.ADDR_W(ADDR_W)) urpa_top_props_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .tx_data_stb(tx_data_stb),
	.baud_divisor(baud_divisor), .prescale_div4(prescale_div4),
	.fifo_256_mode(fifo_256_mode), .xoff_resend_en(xoff_resend_en),
	.flow_mode(flow_mode), .levels(levels), .line_cfg(line_cfg),
	.rx_irq_en(rx_irq_en), .tx_irq_en(tx_irq_en));
